// ### fbg_pkg.sv
package fbg_pkg;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int IRQ_W = 2;

    // register offsets
    localparam logic [3:0] OFS_TX_HOLD = 4'h0;
    localparam logic [3:0] OFS_DIV_LOW = 4'h1;
    localparam logic [3:0] OFS_DIV_HIGH = 4'h2;
    localparam logic [3:0] OFS_DIV_FRAC = 4'h3;
    localparam logic [3:0] OFS_MODEM_CTRL = 4'h4;
    localparam logic [3:0] OFS_LINE_CTRL = 4'h5;
    localparam logic [3:0] OFS_LINE_STAT = 4'h6;
    localparam logic [3:0] OFS_FIFO_CTRL = 4'h7;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h9;

    // reset values
    localparam logic [7:0] RST_DIV_LOW = 8'h01;
    localparam logic [7:0] RST_DIV_HIGH = 8'h00;
    localparam logic [7:0] RST_DIV_FRAC = 8'h00;
    localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
    localparam logic [7:0] RST_LINE_CTRL = 8'h03;
    localparam logic [7:0] RST_FIFO_CTRL = 8'h00;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;

    // implemented bits
    localparam logic [7:0] FRAC_IMPL_MASK = 8'h3f;
    localparam logic [7:0] LINE_IMPL_MASK = 8'h1f;

    // field positions
    localparam int MCR_PRESCALE_BIT = 7;
    localparam int FRAC_LSB = 0;
    localparam int FRAC_W = 4;
    localparam int OS_LSB = 4;
    localparam int LSR_THR_EMPTY_BIT = 5;
    localparam int LSR_TSR_EMPTY_BIT = 6;
    localparam int FIFO_EN_BIT = 0;
    localparam int IRQ_THR_BIT = 0;
    localparam int IRQ_TSR_BIT = 1;

    // oversampling codes and last sample index per bit
    localparam logic [1:0] OS_16X = 2'h0;
    localparam logic [1:0] OS_8X = 2'h1;
    localparam logic [1:0] OS_4X = 2'h2;
    localparam logic [3:0] OS_LAST_16X = 4'hf;
    localparam logic [3:0] OS_LAST_8X = 4'h7;
    localparam logic [3:0] OS_LAST_4X = 4'h3;

    // divide-by-four prescaler wraps at this count
    localparam logic [1:0] PRESCALE_LAST = 2'h3;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} fbg_tx_state_e;

    // low five bits of the line control register
    typedef struct packed {
        logic par_even;
        logic par_en;
        logic two_stop;
        logic [1:0] wlen;
    } fbg_frame_s;

endpackage

// ### fbg_uart_channel.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module fbg_uart_channel #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [fbg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fbg_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [fbg_pkg::DATA_W-1:0] o_rdata,
    output logic o_txd,
    output logic o_sample_tick,
    output logic o_irq
);
    import fbg_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(FIFO_DEPTH);

    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("fifo depth must be a power of two of at least two");
        end
    endgenerate

    // register file
    logic [7:0] div_low_r;
    logic [7:0] div_high_r;
    logic [7:0] div_frac_r;
    logic [7:0] modem_ctrl_r;
    logic [7:0] line_ctrl_r;
    logic [7:0] fifo_ctrl_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [7:0] rdata_r;
    logic irq_r;

    // address decode
    wire logic wr_hold = i_wr && (i_addr == OFS_TX_HOLD);
    wire logic wr_div_low = i_wr && (i_addr == OFS_DIV_LOW);
    wire logic wr_div_high = i_wr && (i_addr == OFS_DIV_HIGH);
    wire logic wr_div_frac = i_wr && (i_addr == OFS_DIV_FRAC);
    wire logic wr_modem = i_wr && (i_addr == OFS_MODEM_CTRL);
    wire logic wr_line = i_wr && (i_addr == OFS_LINE_CTRL);
    wire logic wr_fifo = i_wr && (i_addr == OFS_FIFO_CTRL);
    wire logic wr_irq_stat = i_wr && (i_addr == OFS_IRQ_STAT);
    wire logic wr_irq_mask = i_wr && (i_addr == OFS_IRQ_MASK);

    // prescaler
    logic [1:0] pre_cnt_r;
    wire logic pre_en = modem_ctrl_r[MCR_PRESCALE_BIT];
    wire logic pre_tick = !pre_en || (pre_cnt_r == PRESCALE_LAST);

    // fractional divisor
    logic [16:0] div_cnt_r;
    logic [3:0] acc_r;
    logic stretch_r;
    wire logic [15:0] div_int = {div_high_r, div_low_r};
    wire logic [15:0] div_eff = (div_int == 16'h0000) ? 16'h0001 : div_int;
    wire logic [FRAC_W-1:0] frac = div_frac_r[FRAC_LSB +: FRAC_W];
    wire logic [16:0] period_len = {1'b0, div_eff} + {16'h0000, stretch_r};
    wire logic sample_tick = pre_tick && (div_cnt_r >= period_len - 17'h00001);
    wire logic [4:0] acc_sum = {1'b0, acc_r} + {1'b0, frac};

    // oversampling
    logic [3:0] os_cnt_r;
    wire logic [1:0] os_mode = div_frac_r[OS_LSB +: 2];
    wire logic [3:0] os_last = (os_mode == OS_8X) ? OS_LAST_8X :
                               (os_mode == OS_4X) ? OS_LAST_4X : OS_LAST_16X;
    wire logic bit_tick = sample_tick && (os_cnt_r >= os_last);

    // transmit fifo
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0] fifo_cnt_r;
    logic [PTR_W:0] fifo_cnt_nxt;
    wire logic fifo_en = fifo_ctrl_r[FIFO_EN_BIT];
    wire logic fifo_flush = wr_fifo && (i_wdata[FIFO_EN_BIT] != fifo_en);
    wire logic fifo_full = fifo_en ? (fifo_cnt_r == DEPTH_CNT) : (fifo_cnt_r != '0);
    wire logic fifo_push = wr_hold && !fifo_full && !fifo_flush;
    wire logic fifo_avail = (fifo_cnt_r != '0) && !fifo_flush;
    wire logic thr_empty = (fifo_cnt_r == '0);
    logic load;

    // transmitter
    fbg_tx_state_e state_r;
    fbg_tx_state_e state_nxt;
    logic [7:0] tsr_r;
    logic [7:0] tsr_nxt;
    logic [2:0] idx_r;
    logic [2:0] idx_nxt;
    logic stop_r;
    logic stop_nxt;
    logic par_r;
    logic par_nxt;
    logic txd_r;
    logic txd_nxt;
    wire fbg_frame_s frame = fbg_frame_s'(line_ctrl_r[4:0]);
    wire logic [2:0] idx_last = {1'b1, frame.wlen};
    wire logic [7:0] data_mask = 8'hff >> (2'h3 - frame.wlen);
    wire logic [7:0] head_data = fifo_mem[rd_ptr_r] & data_mask;
    wire logic head_par = frame.par_even ? (^head_data) : (~^head_data);
    wire logic tsr_empty = thr_empty && (state_r == TX_IDLE);

    // interrupts
    logic thr_empty_q;
    logic tsr_empty_q;
    wire logic [IRQ_W-1:0] irq_events = {tsr_empty && !tsr_empty_q, thr_empty && !thr_empty_q};
    wire logic [IRQ_W-1:0] irq_clear = wr_irq_stat ? i_wdata[IRQ_W-1:0] : '0;
    wire logic [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clear) | irq_events;
    wire logic [IRQ_W-1:0] irq_mask_nxt = wr_irq_mask ? i_wdata[IRQ_W-1:0] : irq_mask_r;

    // read selection
    wire logic [7:0] lsr_val = {1'b0, tsr_empty, thr_empty, 5'h00};
    wire logic [7:0] rd_mux =
        (i_addr == OFS_DIV_LOW) ? div_low_r :
        (i_addr == OFS_DIV_HIGH) ? div_high_r :
        (i_addr == OFS_DIV_FRAC) ? div_frac_r :
        (i_addr == OFS_MODEM_CTRL) ? modem_ctrl_r :
        (i_addr == OFS_LINE_CTRL) ? line_ctrl_r :
        (i_addr == OFS_LINE_STAT) ? lsr_val :
        (i_addr == OFS_FIFO_CTRL) ? fifo_ctrl_r :
        (i_addr == OFS_IRQ_STAT) ? {6'h00, irq_stat_r} :
        (i_addr == OFS_IRQ_MASK) ? {6'h00, irq_mask_r} : 8'h00;

    assign o_rdata = rdata_r;
    assign o_txd = txd_r;
    assign o_irq = irq_r;

    // registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_low_r <= RST_DIV_LOW;
            div_high_r <= RST_DIV_HIGH;
            div_frac_r <= RST_DIV_FRAC;
            modem_ctrl_r <= RST_MODEM_CTRL;
            line_ctrl_r <= RST_LINE_CTRL;
            fifo_ctrl_r <= RST_FIFO_CTRL;
            irq_mask_r <= RST_IRQ_MASK;
        end else begin
            if (wr_div_low) div_low_r <= i_wdata;
            if (wr_div_high) div_high_r <= i_wdata;
            if (wr_div_frac) div_frac_r <= i_wdata & FRAC_IMPL_MASK;
            if (wr_modem) modem_ctrl_r <= i_wdata;
            if (wr_line) line_ctrl_r <= i_wdata & LINE_IMPL_MASK;
            if (wr_fifo) fifo_ctrl_r <= {7'h00, i_wdata[FIFO_EN_BIT]};
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // read data and interrupt
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_r <= 8'h00;
            irq_stat_r <= '0;
            irq_r <= 1'b0;
            thr_empty_q <= 1'b1;
            tsr_empty_q <= 1'b1;
        end else begin
            rdata_r <= i_rd ? rd_mux : 8'h00;
            irq_stat_r <= irq_stat_nxt;
            irq_r <= |(irq_stat_nxt & irq_mask_nxt);
            thr_empty_q <= thr_empty;
            tsr_empty_q <= tsr_empty;
        end
    end

    // baud generator
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pre_cnt_r <= 2'h0;
            div_cnt_r <= 17'h00000;
            acc_r <= 4'h0;
            stretch_r <= 1'b0;
            os_cnt_r <= 4'h0;
            o_sample_tick <= 1'b0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 2'h1;
            if (pre_tick) div_cnt_r <= sample_tick ? 17'h00000 : div_cnt_r + 17'h00001;
            if (sample_tick) begin
                acc_r <= acc_sum[3:0];
                stretch_r <= acc_sum[4];
                os_cnt_r <= bit_tick ? 4'h0 : os_cnt_r + 4'h1;
            end
            o_sample_tick <= sample_tick;
        end
    end

    // fifo
    always_comb begin
        fifo_cnt_nxt = fifo_cnt_r;
        if (fifo_flush) fifo_cnt_nxt = '0;
        else if (fifo_push && !load) fifo_cnt_nxt = fifo_cnt_r + 1'b1;
        else if (load && !fifo_push) fifo_cnt_nxt = fifo_cnt_r - 1'b1;
    end

    always_ff @(posedge i_clk) begin
        if (fifo_push) fifo_mem[wr_ptr_r] <= i_wdata;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || fifo_flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fifo_cnt_r <= '0;
        end else begin
            if (fifo_push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (load) rd_ptr_r <= rd_ptr_r + 1'b1;
            fifo_cnt_r <= fifo_cnt_nxt;
        end
    end

    // transmit framing
    always_comb begin
        state_nxt = state_r;
        tsr_nxt = tsr_r;
        idx_nxt = idx_r;
        stop_nxt = stop_r;
        par_nxt = par_r;
        txd_nxt = txd_r;
        load = 1'b0;
        if (bit_tick) begin
            unique case (state_r)
                TX_IDLE: begin
                    load = fifo_avail;
                end
                TX_START: begin
                    txd_nxt = tsr_r[0];
                    tsr_nxt = {1'b0, tsr_r[7:1]};
                    idx_nxt = 3'h0;
                    state_nxt = TX_DATA;
                end
                TX_DATA: begin
                    if (idx_r == idx_last) begin
                        if (frame.par_en) begin
                            txd_nxt = par_r;
                            state_nxt = TX_PARITY;
                        end else begin
                            txd_nxt = 1'b1;
                            stop_nxt = frame.two_stop;
                            state_nxt = TX_STOP;
                        end
                    end else begin
                        txd_nxt = tsr_r[0];
                        tsr_nxt = {1'b0, tsr_r[7:1]};
                        idx_nxt = idx_r + 3'h1;
                    end
                end
                TX_PARITY: begin
                    txd_nxt = 1'b1;
                    stop_nxt = frame.two_stop;
                    state_nxt = TX_STOP;
                end
                TX_STOP: begin
                    if (stop_r) begin
                        stop_nxt = 1'b0;
                    end else begin
                        load = fifo_avail;
                        state_nxt = TX_IDLE;
                    end
                end
            endcase
        end
        if (load) begin
            txd_nxt = 1'b0;
            tsr_nxt = head_data;
            par_nxt = head_par;
            state_nxt = TX_START;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= TX_IDLE;
            tsr_r <= 8'h00;
            idx_r <= 3'h0;
            stop_r <= 1'b0;
            par_r <= 1'b0;
            txd_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            tsr_r <= tsr_nxt;
            idx_r <= idx_nxt;
            stop_r <= stop_nxt;
            par_r <= par_nxt;
            txd_r <= txd_nxt;
        end
    end

    // assertion helpers: carries over a sixteen-period window
    logic [3:0] h_idx_r;
    logic [4:0] h_extra_r;

    always_ff @(posedge i_clk) begin
        if (i_srst || wr_div_frac) begin
            h_idx_r <= 4'h0;
            h_extra_r <= 5'h00;
        end else if (sample_tick) begin
            h_idx_r <= h_idx_r + 4'h1;
            h_extra_r <= (h_idx_r == 4'hf) ? 5'h00 : h_extra_r + {4'h0, acc_sum[4]};
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_load_char;
        load && (state_r == TX_IDLE || state_r == TX_STOP);
    endsequence

    sequence s_start_bit;
        (state_r == TX_START) && !o_txd;
    endsequence

    a_divisor_reset: assert property ($past(i_srst) |-> div_low_r == RST_DIV_LOW && div_high_r == RST_DIV_HIGH
        && div_frac_r == RST_DIV_FRAC)
        else $error("divisor registers not at reset value");

    a_prescale_gap: assert property ((pre_tick && pre_en) |=> (!pre_tick || !pre_en) [*3])
        else $error("prescaler ticks closer than four clocks");

    a_prescale_off: assert property (!pre_en |-> pre_tick)
        else $error("prescaler bypass does not pass every clock");

    a_frac_extras: assert property ((sample_tick && !wr_div_frac && h_idx_r == 4'hf)
        |-> (h_extra_r + {4'h0, acc_sum[4]}) == {1'b0, frac})
        else $error("stretched periods per sixteen differ from fraction code");

    a_tx_bit_edge: assert property ((o_txd != $past(o_txd)) |-> $past(bit_tick))
        else $error("serial output changed off a bit boundary");

    a_start_first: assert property (s_load_char |=> s_start_bit)
        else $error("character did not open with a start bit");

    a_lsb_first: assert property ((state_r == TX_START && bit_tick) |=> o_txd == $past(tsr_r[0]))
        else $error("first data bit is not bit zero");

    a_stop_high: assert property ((state_r == TX_STOP) |-> o_txd)
        else $error("stop bit not high");

    a_lsr_flags: assert property ((i_rd && i_addr == OFS_LINE_STAT)
        |=> o_rdata[6:5] == {$past(tsr_empty), $past(fifo_cnt_r == '0)})
        else $error("line status empty flags wrong");

    a_fifo_bound: assert property (fifo_cnt_r <= DEPTH_CNT && (fifo_en || fifo_cnt_r <= 1))
        else $error("fifo count beyond capacity");

    a_tick_nested: assert property (bit_tick |-> sample_tick && pre_tick)
        else $error("bit boundary not on a sampling tick");

    a_irq_set_wins: assert property ((irq_events != '0) |=> (irq_stat_r & $past(irq_events)) == $past(irq_events))
        else $error("status event lost");

    a_irq_level: assert property (o_irq == |(irq_stat_r & irq_mask_r))
        else $error("interrupt output does not follow masked status");

endmodule // fbg_uart_channel

// ### fbg_remote_rx.sv
`timescale 1ns/1ps

// remote receiver on the serial line: finds the start bit, samples mid-bit
module fbg_remote_rx (
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic [7:0] i_bit_clks,
    input wire logic [3:0] i_nbits,
    output logic [8:0] o_data,
    output logic o_stop,
    output logic [7:0] o_count
);
    initial begin
        o_data = '0;
        o_stop = 1'b0;
        o_count = '0;
    end

    always begin : rx_loop
        logic [8:0] d;
        @(posedge i_clk);
        if (i_txd === 1'b0) begin
            d = '0;
            repeat (i_bit_clks / 2) @(posedge i_clk);
            // data then parity follow the start bit, lsb first
            for (int i = 0; i < i_nbits; i++) begin
                repeat (i_bit_clks) @(posedge i_clk);
                d[i] = i_txd;
            end
            repeat (i_bit_clks) @(posedge i_clk);
            o_stop = i_txd;
            o_data = d;
            o_count = o_count + 8'h01;
        end
    end
endmodule // fbg_remote_rx

// ### test_fractional_baud_gen_tx.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module test_fractional_baud_gen_tx;
    import fbg_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic o_txd;
    logic o_sample_tick;
    logic o_irq;
    logic [7:0] bitc = 8'h10;
    logic [3:0] nbits = 4'h8;
    logic [8:0] rx_data;
    logic rx_stop;
    logic [7:0] rx_cnt;
    logic [7:0] v;
    int miscompares = 0;
    int checked = 0;
    int c;
    logic [7:0] tk_hi [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0] tk_lo [5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h00};
    logic [7:0] tk_fr [5] = '{8'h00, 8'h05, 8'h00, 8'h05, 8'h00};
    logic [7:0] tk_mc [5] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
    int tk_n [5] = '{16, 16, 16, 16, 1};
    int tk_exp [5] = '{48, 53, 192, 212, 256};
    logic [1:0] os_tab [3] = '{OS_16X, OS_8X, OS_4X};
    logic [3:0] os_last [3] = '{OS_LAST_16X, OS_LAST_8X, OS_LAST_4X};
    logic [7:0] fifo_b [3] = '{8'h81, 8'h42, 8'h3c};

    fbg_uart_channel #(.FIFO_DEPTH(16)) i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_txd(o_txd), .o_sample_tick(o_sample_tick), .o_irq(o_irq));

    fbg_remote_rx i_remote (.i_clk(i_clk), .i_txd(o_txd), .i_bit_clks(bitc), .i_nbits(nbits),
        .o_data(rx_data), .o_stop(rx_stop), .o_count(rx_cnt));

    always #20 i_clk = ~i_clk;

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        rd(a, v);
        `CHK(v, e)
    endtask

    task irq_is(input logic e);
        repeat (2) @(posedge i_clk);
        #1;
        `CHK(o_irq, e)
    endtask

    // clocks spanned by n sampling periods, after skipping two ticks
    task tick_span(input int n, output int cl);
        int t;
        int k;
        t = 0;
        cl = 0;
        for (k = 0; k < 4000 && t < 2; k++) begin
            @(posedge i_clk);
            #1;
            if (o_sample_tick === 1'b1) t++;
        end
        t = 0;
        for (k = 0; k < 8000 && t < n; k++) begin
            @(posedge i_clk);
            #1;
            cl++;
            if (o_sample_tick === 1'b1) t++;
        end
    endtask

    task wait_rx(input logic [7:0] target);
        for (int k = 0; k < 20000 && rx_cnt !== target; k++) @(posedge i_clk);
        `CHK(rx_cnt, target)
    endtask

    task send_check(input logic [7:0] lc, input logic [7:0] b, input logic [3:0] nb, input logic [8:0] e);
        logic [7:0] n0;
        wr(OFS_LINE_CTRL, lc);
        nbits = nb;
        n0 = rx_cnt;
        wr(OFS_TX_HOLD, b);
        wait_rx(n0 + 8'h01);
        `CHK(rx_data, e)
        `CHK(rx_stop, 1'b1)
        repeat (2 * bitc) @(posedge i_clk);
    endtask

    task wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_clk);
        miscompares++;
        $display("unexpected timeout at %0t", $time);
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        rd_chk(OFS_DIV_LOW, RST_DIV_LOW);
        rd_chk(OFS_DIV_HIGH, RST_DIV_HIGH);
        rd_chk(OFS_DIV_FRAC, RST_DIV_FRAC);
        rd_chk(OFS_LINE_STAT, 8'h60);
        rd_chk(4'hf, 8'h00);
        wr(OFS_DIV_HIGH, 8'h12);
        wr(OFS_DIV_LOW, 8'h34);
        wr(OFS_DIV_FRAC, 8'hff);
        rd_chk(OFS_DIV_HIGH, 8'h12);
        rd_chk(OFS_DIV_LOW, 8'h34);
        rd_chk(OFS_DIV_FRAC, 8'h3f);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_DIV_HIGH, tk_hi[i]);
            wr(OFS_DIV_LOW, tk_lo[i]);
            wr(OFS_DIV_FRAC, tk_fr[i]);
            wr(OFS_MODEM_CTRL, tk_mc[i]);
            tick_span(tk_n[i], c);
            `CHK(c, tk_exp[i])
        end
        wr(OFS_MODEM_CTRL, 8'h00);
        wr(OFS_DIV_HIGH, 8'h00);
        wr(OFS_DIV_LOW, 8'h01);
        for (int j = 0; j < 3; j++) begin
            wr(OFS_DIV_FRAC, {2'h0, os_tab[j], 4'h0});
            bitc = {4'h0, os_last[j]} + 8'h01;
            send_check(8'h03, 8'h4b, 4'h8, 9'h04b);
        end
        send_check(8'h0b, 8'ha5, 4'h9, 9'h1a5);
        send_check(8'h1b, 8'ha5, 4'h9, 9'h0a5);
        send_check(8'h1a, 8'h81, 4'h8, 9'h081);
        send_check(8'h00, 8'hff, 4'h5, 9'h01f);
        rd_chk(OFS_LINE_STAT, 8'h60);
        rd_chk(OFS_IRQ_STAT, 8'h03);
        wr(OFS_LINE_CTRL, 8'h07);
        wr(OFS_DIV_FRAC, 8'h00);
        wr(OFS_DIV_LOW, 8'h04);
        wr(OFS_FIFO_CTRL, 8'h01);
        bitc = 8'h40;
        // two stop bits: first stop lands in rx bit 8, second in the stop sample
        nbits = 4'h9;
        c = rx_cnt;
        for (int i = 0; i < 3; i++) wr(OFS_TX_HOLD, fifo_b[i]);
        rd_chk(OFS_LINE_STAT, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wait_rx(c[7:0] + i[7:0] + 8'h01);
            `CHK(rx_data[7:0], fifo_b[i])
            `CHK({rx_stop, rx_data[8]}, 2'h3)
        end
        repeat (2 * bitc) @(posedge i_clk);
        rd_chk(OFS_LINE_STAT, 8'h60);
        wr(OFS_IRQ_STAT, 8'h03);
        rd_chk(OFS_IRQ_STAT, 8'h00);
        wr(OFS_IRQ_MASK, 8'h02);
        irq_is(1'b0);
        send_check(8'h03, 8'h5a, 4'h8, 9'h05a);
        irq_is(1'b1);
        wr(OFS_IRQ_STAT, 8'h02);
        irq_is(1'b0);
        wr(OFS_IRQ_MASK, 8'h03);
        irq_is(1'b1);
        wr(OFS_IRQ_STAT, 8'h01);
        irq_is(1'b0);
        // reset in mid-run restores the divisor and clears the mask
        wr(OFS_DIV_LOW, 8'h09);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        rd_chk(OFS_DIV_LOW, RST_DIV_LOW);
        rd_chk(OFS_IRQ_MASK, 8'h00);
        rd_chk(OFS_LINE_STAT, 8'h60);
        wrap_up();
    end
endmodule // test_fractional_baud_gen_tx
